// [hw/rqe_encoder.sv]
// Receive event word encoder: turns producer conditions into queue event words.
//
// Notes on behaviour
// - Out-of-range path/channel cell posts 0x0c, zero channel index 0x0d, with cell pointer.
// - No-buffer drops post 0x10, 0x11 or 0x12 with channel descriptor pointer.
// - FIFO-mode cell dropped on full channel FIFO posts 0x13 with descriptor pointer.
// - FIFO threshold 0x14, FIFO full 0x15, FIFO timeout 0x16, descriptor pointer.
// - Cell counter overflows post 0x18, 0x19, 0x1a, 0x1b with descriptor pointer.
// - ABR events go to the ABR routing queue, not the channel's queue.
// - ACR decrease timer expiry posts 0x2c with descriptor pointer.
// - Too many RM cells without backward RM posts 0x2d with descriptor pointer.
// - Current cell rate zero posts 0x2e; RM cell received posts 0x2f with buffer.
// - Threshold 1 or 2 crossing posts 0x1e or 0x1f; bit six gives direction.
// - Transmit done posts 0x20, or 0x21 if freed, with buffer pointer.
// - Bad-marked transmit buffer cancels transmission and posts 0x22 with buffer.
// - Channel drained after closure posts 0x23 with descriptor address.
// - DMA success posts 0x24/0x25, errors 0x26/0x27, info as set up.
// - Virtual error 0x28 or zero address 0x29 abandons descriptor, posts its address.
// - Virtual segment or size overflow posts 0x38 with packet or channel pointer.
// - Real buffer overflow posts 0x39, packet pointer in bad-frame mode else descriptor.
// - Cut-through: no header descriptor 0x3a; error-cancelled DMA 0x3b with descriptor.
// - Scatter pages exhausted on good packet posts 0x3c with internal buffer.
// - Global counter overflows post 0x3d with bitmap in bits 31 down to 23.
// - Buffer pool status condition posts 0x3e carrying the pool status.
// - With timestamping on, a 0x3f stamp word goes just ahead of its event.
// - Every event is one 32-bit queue entry.
// - Type in six low bits, information field in the upper bits.
`timescale 1ns/100ps
module rqe_encoder
  import rqe_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Request from producers and software enqueue.
  input wire logic i_req_valid,
  input wire rqe_req_t i_req,
  output logic o_req_ready,
  // Routing and timestamp settings.
  input wire logic [RQE_QUEUE_W-1:0] i_abr_queue,
  input wire logic i_ts_enable,
  input wire logic [RQE_INFO_W-1:0] i_timestamp,
  // Event word to the receive queue.
  output logic o_evt_valid,
  output rqe_evt_t o_evt,
  input wire logic i_evt_ready,
  // Side effects toward the transmit and DMA engines.
  output logic o_tx_cancel,
  output logic o_desc_abandon
);

  typedef enum logic [1:0] {
    RQE_S_IDLE = 2'b00,
    RQE_S_STAMP = 2'b01,
    RQE_S_EVENT = 2'b10
  } rqe_state_t;

  // Type code for a cause; the reserved code has no cause that maps to it.
  function automatic logic [RQE_TYPE_W-1:0] evt_type(input rqe_req_t r);
    logic [RQE_TYPE_W-1:0] t;
    t = RQE_T_POOL;
    case (r.cause)
      RQE_C_CELL_RANGE: t = RQE_T_CELL_RANGE;
      RQE_C_CELL_IDX0: t = RQE_T_CELL_IDX0;
      RQE_C_DROP_AAL0: t = RQE_T_DROP_AAL0;
      RQE_C_DROP_AAL5: t = RQE_T_DROP_AAL5;
      RQE_C_DROP_NUD: t = RQE_T_DROP_NUD;
      RQE_C_FIFO_DROP: t = RQE_T_FIFO_DROP;
      RQE_C_FIFO_THR: t = RQE_T_FIFO_THR;
      RQE_C_FIFO_FULL: t = RQE_T_FIFO_FULL;
      RQE_C_FIFO_RTO: t = RQE_T_FIFO_RTO;
      RQE_C_TUC_RX: t = RQE_T_TUC_RX;
      RQE_C_TUC_RX0: t = RQE_T_TUC_RX0;
      RQE_C_TUC_TX: t = RQE_T_TUC_TX;
      RQE_C_TUC_TX0: t = RQE_T_TUC_TX0;
      RQE_C_THRESH1: t = RQE_T_THRESH1;
      RQE_C_THRESH2: t = RQE_T_THRESH2;
      RQE_C_TX_DONE: t = RQE_T_TX_DONE;
      RQE_C_TX_FREED: t = RQE_T_TX_FREED;
      RQE_C_TX_BAD: t = RQE_T_TX_BAD;
      RQE_C_CONN_CLOSED: t = RQE_T_CONN_CLOSED;
      RQE_C_DMA_TX_OK: t = RQE_T_DMA_TX_OK;
      RQE_C_DMA_RX_OK: t = RQE_T_DMA_RX_OK;
      RQE_C_DMA_TX_ERR: t = RQE_T_DMA_TX_ERR;
      RQE_C_DMA_RX_ERR: t = RQE_T_DMA_RX_ERR;
      RQE_C_DMA_VIRT: t = RQE_T_DMA_VIRT;
      RQE_C_DMA_ZERO: t = RQE_T_DMA_ZERO;
      RQE_C_ABR_ADT: t = RQE_T_ABR_ADT;
      RQE_C_ABR_NO_BRM: t = RQE_T_ABR_NO_BRM;
      RQE_C_ABR_CCR0: t = RQE_T_ABR_CCR0;
      RQE_C_ABR_RM_RX: t = RQE_T_ABR_RM_RX;
      RQE_C_VMEM: t = RQE_T_VMEM;
      RQE_C_BUF_OVF: t = RQE_T_BUF_OVF;
      RQE_C_CT_NO_DESC: t = RQE_T_CT_NO_DESC;
      RQE_C_CT_CANCEL: t = RQE_T_CT_CANCEL;
      RQE_C_SCATTER: t = RQE_T_SCATTER;
      RQE_C_CTR_OVF: t = RQE_T_CTR_OVF;
      RQE_C_POOL: t = RQE_T_POOL;
      RQE_C_USER: t = RQE_T_USER_BASE | {3'h0, r.user_idx};
      default: t = RQE_T_POOL;
    endcase
    return t;
  endfunction : evt_type

  // Information field; most causes carry the primary pointer unchanged.
  function automatic logic [RQE_INFO_W-1:0] evt_info(input rqe_req_t r);
    logic [RQE_INFO_W-1:0] f;
    f = r.ptr;
    case (r.cause)
      RQE_C_THRESH1, RQE_C_THRESH2: begin
        f = r.ptr;
        f[RQE_DIR_POS] = r.dir_up;
      end
      RQE_C_VMEM, RQE_C_BUF_OVF, RQE_C_CT_NO_DESC: begin
        f = r.bad_frames ? r.pkt_ptr : r.ptr;
      end
      RQE_C_CTR_OVF: begin
        f = {r.ctr_map, {(RQE_INFO_W-RQE_CTR_W){1'b0}}};
      end
      default: f = r.ptr;
    endcase
    return f;
  endfunction : evt_info

  // ABR events take their queue from the ABR routing setting.
  function automatic logic is_abr(input rqe_cause_t c);
    return (c == RQE_C_ABR_ADT) || (c == RQE_C_ABR_NO_BRM) ||
           (c == RQE_C_ABR_CCR0) || (c == RQE_C_ABR_RM_RX);
  endfunction : is_abr

  rqe_state_t state_r;
  rqe_evt_t pend_r;
  logic accept;
  logic drain;
  rqe_evt_t word_nxt;

  assign accept = i_req_valid && o_req_ready;
  assign drain = o_evt_valid && i_evt_ready;

  // Whole entry is built at once so the queue never sees a half word.
  always_comb begin
    word_nxt.queue = is_abr(i_req.cause) ? i_abr_queue : i_req.queue;
    word_nxt.word = {evt_info(i_req), evt_type(i_req)};
  end

  // Sequencer: one request at a time, stamp word first when enabled.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= RQE_S_IDLE;
      o_req_ready <= RQE_READY_RST;
    end else begin
      case (state_r)
        RQE_S_IDLE: begin
          if (accept) begin
            o_req_ready <= 1'b0;
            state_r <= i_ts_enable ? RQE_S_STAMP : RQE_S_EVENT;
          end
        end
        RQE_S_STAMP: begin
          if (drain) begin
            state_r <= RQE_S_EVENT;
          end
        end
        RQE_S_EVENT: begin
          if (drain) begin
            state_r <= RQE_S_IDLE;
            o_req_ready <= 1'b1;
          end
        end
        default: begin
          state_r <= RQE_S_IDLE;
          o_req_ready <= 1'b1;
        end
      endcase
    end
  end

  // Output word; the real event waits in pend_r while the stamp is offered.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_evt_valid <= 1'b0;
      o_evt <= '0;
      pend_r <= '0;
    end else if (accept) begin
      o_evt_valid <= 1'b1;
      pend_r <= word_nxt;
      if (i_ts_enable) begin
        o_evt.queue <= word_nxt.queue;
        o_evt.word <= {i_timestamp, RQE_T_STAMP};
      end else begin
        o_evt <= word_nxt;
      end
    end else if (drain) begin
      if (state_r == RQE_S_STAMP) begin
        o_evt <= pend_r;
      end else begin
        o_evt_valid <= 1'b0;
        o_evt.word <= RQE_WORD_RST;
      end
    end
  end

  // Side effects are single registered pulses, the cycle after acceptance of the causing request.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tx_cancel <= 1'b0;
      o_desc_abandon <= 1'b0;
    end else begin
      o_tx_cancel <= accept && (i_req.cause == RQE_C_TX_BAD);
      o_desc_abandon <= accept &&
        ((i_req.cause == RQE_C_DMA_VIRT) || (i_req.cause == RQE_C_DMA_ZERO));
    end
  end

  // Checks on the words handed to the queue.
  property p_cell_word;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable && i_req.cause == RQE_C_CELL_RANGE) |=>
      (o_evt_valid && o_evt.word == {$past(i_req.ptr), RQE_T_CELL_RANGE});
  endproperty
  a_cell_word: assert property (p_cell_word) else $error("Out-of-range cell word wrong.");

  property p_drop_word;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable && i_req.cause == RQE_C_DROP_AAL5) |=>
      (o_evt.word[5:0] == 6'h11 && o_evt.word[31:6] == $past(i_req.ptr));
  endproperty
  a_drop_word: assert property (p_drop_word) else $error("Buffer drop word wrong.");

  property p_abr_route;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && is_abr(i_req.cause)) |=> (o_evt.queue == $past(i_abr_queue));
  endproperty
  a_abr_route: assert property (p_abr_route) else $error("ABR event misrouted.");

  property p_thresh_dir;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable && i_req.cause == RQE_C_THRESH2) |=>
      (o_evt.word[5:0] == 6'h1F && o_evt.word[6] == $past(i_req.dir_up));
  endproperty
  a_thresh_dir: assert property (p_thresh_dir) else $error("Threshold direction wrong.");

  property p_tx_cancel;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && i_req.cause == RQE_C_TX_BAD) |=> (o_tx_cancel ##1 !o_tx_cancel);
  endproperty
  a_tx_cancel: assert property (p_tx_cancel) else $error("Transmit cancel not pulsed.");

  property p_abandon;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    o_desc_abandon |-> (o_evt_valid && $past(i_req.cause) inside {RQE_C_DMA_VIRT, RQE_C_DMA_ZERO});
  endproperty
  a_abandon: assert property (p_abandon) else $error("Descriptor abandoned without cause.");

  property p_overflow_map;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable && i_req.cause == RQE_C_CTR_OVF) |=>
      (o_evt.word == {$past(i_req.ctr_map), 17'h0, 6'h3D});
  endproperty
  a_overflow_map: assert property (p_overflow_map) else $error("Overflow bitmap wrong.");

  // Stamp word comes first, then the pending event with no word lost between them.
  property p_stamp_first;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && i_ts_enable) |=>
      (o_evt_valid && state_r == RQE_S_STAMP &&
       o_evt.word == {$past(i_timestamp), RQE_T_STAMP});
  endproperty
  a_stamp_first: assert property (p_stamp_first) else $error("Stamp not ahead of event.");

  property p_stamp_next;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (state_r == RQE_S_STAMP && drain) |=>
      (o_evt_valid && state_r == RQE_S_EVENT && o_evt == $past(pend_r));
  endproperty
  a_stamp_next: assert property (p_stamp_next) else $error("Event lost after stamp.");

  property p_bad_frame_ptr;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable && i_req.cause == RQE_C_BUF_OVF) |=>
      (o_evt.word[31:6] == ($past(i_req.bad_frames) ? $past(i_req.pkt_ptr) : $past(i_req.ptr)));
  endproperty
  a_bad_frame_ptr: assert property (p_bad_frame_ptr) else $error("Overflow pointer wrong.");

  property p_no_reserved;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    o_evt_valid |-> (o_evt.word[5:0] != RQE_T_RESERVED);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("Reserved type emitted.");

  // User codes appear exactly when software asked for one; no producer cause may borrow them.
  property p_user_only;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (accept && !i_ts_enable) |=>
      ((o_evt.word[5:3] == 3'h6) == ($past(i_req.cause) == RQE_C_USER));
  endproperty
  a_user_only: assert property (p_user_only) else $error("User code misused.");

  property p_held;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
    (o_evt_valid && !i_evt_ready) |=> (o_evt_valid && $stable(o_evt));
  endproperty
  a_held: assert property (p_held) else $error("Word changed while stalled.");

endmodule : rqe_encoder

// [hw/rqe_pkg.sv]
// Package for the receive event word encoder: type codes, causes and request layout.
package rqe_pkg;

  // Word layout: six-bit type in the low bits, information field above it.
  localparam int RQE_WORD_W = 32;
  localparam int RQE_TYPE_W = 6;
  localparam int RQE_INFO_W = RQE_WORD_W - RQE_TYPE_W;
  localparam int RQE_QUEUE_W = 4;
  localparam int RQE_CTR_W = 9;
  localparam int RQE_USER_W = 3;

  // Values after reset.
  localparam logic RQE_READY_RST = 1'b1;
  localparam logic [RQE_WORD_W-1:0] RQE_WORD_RST = 32'h0000_0000;

  // Event type codes.
  localparam logic [5:0] RQE_T_CELL_RANGE = 6'h0C;
  localparam logic [5:0] RQE_T_CELL_IDX0 = 6'h0D;
  localparam logic [5:0] RQE_T_DROP_AAL0 = 6'h10;
  localparam logic [5:0] RQE_T_DROP_AAL5 = 6'h11;
  localparam logic [5:0] RQE_T_DROP_NUD = 6'h12;
  localparam logic [5:0] RQE_T_FIFO_DROP = 6'h13;
  localparam logic [5:0] RQE_T_FIFO_THR = 6'h14;
  localparam logic [5:0] RQE_T_FIFO_FULL = 6'h15;
  localparam logic [5:0] RQE_T_FIFO_RTO = 6'h16;
  localparam logic [5:0] RQE_T_RESERVED = 6'h17;
  localparam logic [5:0] RQE_T_TUC_RX = 6'h18;
  localparam logic [5:0] RQE_T_TUC_RX0 = 6'h19;
  localparam logic [5:0] RQE_T_TUC_TX = 6'h1A;
  localparam logic [5:0] RQE_T_TUC_TX0 = 6'h1B;
  localparam logic [5:0] RQE_T_THRESH1 = 6'h1E;
  localparam logic [5:0] RQE_T_THRESH2 = 6'h1F;
  localparam logic [5:0] RQE_T_TX_DONE = 6'h20;
  localparam logic [5:0] RQE_T_TX_FREED = 6'h21;
  localparam logic [5:0] RQE_T_TX_BAD = 6'h22;
  localparam logic [5:0] RQE_T_CONN_CLOSED = 6'h23;
  localparam logic [5:0] RQE_T_DMA_TX_OK = 6'h24;
  localparam logic [5:0] RQE_T_DMA_RX_OK = 6'h25;
  localparam logic [5:0] RQE_T_DMA_TX_ERR = 6'h26;
  localparam logic [5:0] RQE_T_DMA_RX_ERR = 6'h27;
  localparam logic [5:0] RQE_T_DMA_VIRT = 6'h28;
  localparam logic [5:0] RQE_T_DMA_ZERO = 6'h29;
  localparam logic [5:0] RQE_T_ABR_ADT = 6'h2C;
  localparam logic [5:0] RQE_T_ABR_NO_BRM = 6'h2D;
  localparam logic [5:0] RQE_T_ABR_CCR0 = 6'h2E;
  localparam logic [5:0] RQE_T_ABR_RM_RX = 6'h2F;
  localparam logic [5:0] RQE_T_USER_BASE = 6'h30;
  localparam logic [5:0] RQE_T_VMEM = 6'h38;
  localparam logic [5:0] RQE_T_BUF_OVF = 6'h39;
  localparam logic [5:0] RQE_T_CT_NO_DESC = 6'h3A;
  localparam logic [5:0] RQE_T_CT_CANCEL = 6'h3B;
  localparam logic [5:0] RQE_T_SCATTER = 6'h3C;
  localparam logic [5:0] RQE_T_CTR_OVF = 6'h3D;
  localparam logic [5:0] RQE_T_POOL = 6'h3E;
  localparam logic [5:0] RQE_T_STAMP = 6'h3F;

  // Direction flag sits at word bit six, the lowest information bit.
  localparam int RQE_DIR_POS = 0;

  // Conditions that producers raise.
  typedef enum logic [5:0] {
    RQE_C_CELL_RANGE = 6'b000000,
    RQE_C_CELL_IDX0 = 6'b000001,
    RQE_C_DROP_AAL0 = 6'b000010,
    RQE_C_DROP_AAL5 = 6'b000011,
    RQE_C_DROP_NUD = 6'b000100,
    RQE_C_FIFO_DROP = 6'b000101,
    RQE_C_FIFO_THR = 6'b000110,
    RQE_C_FIFO_FULL = 6'b000111,
    RQE_C_FIFO_RTO = 6'b001000,
    RQE_C_TUC_RX = 6'b001001,
    RQE_C_TUC_RX0 = 6'b001010,
    RQE_C_TUC_TX = 6'b001011,
    RQE_C_TUC_TX0 = 6'b001100,
    RQE_C_THRESH1 = 6'b001101,
    RQE_C_THRESH2 = 6'b001110,
    RQE_C_TX_DONE = 6'b001111,
    RQE_C_TX_FREED = 6'b010000,
    RQE_C_TX_BAD = 6'b010001,
    RQE_C_CONN_CLOSED = 6'b010010,
    RQE_C_DMA_TX_OK = 6'b010011,
    RQE_C_DMA_RX_OK = 6'b010100,
    RQE_C_DMA_TX_ERR = 6'b010101,
    RQE_C_DMA_RX_ERR = 6'b010110,
    RQE_C_DMA_VIRT = 6'b010111,
    RQE_C_DMA_ZERO = 6'b011000,
    RQE_C_ABR_ADT = 6'b011001,
    RQE_C_ABR_NO_BRM = 6'b011010,
    RQE_C_ABR_CCR0 = 6'b011011,
    RQE_C_ABR_RM_RX = 6'b011100,
    RQE_C_VMEM = 6'b011101,
    RQE_C_BUF_OVF = 6'b011110,
    RQE_C_CT_NO_DESC = 6'b011111,
    RQE_C_CT_CANCEL = 6'b100000,
    RQE_C_SCATTER = 6'b100001,
    RQE_C_CTR_OVF = 6'b100010,
    RQE_C_POOL = 6'b100011,
    RQE_C_USER = 6'b100100
  } rqe_cause_t;

  // One request from a producer or from a software enqueue.
  typedef struct packed {
    rqe_cause_t cause;
    logic [RQE_USER_W-1:0] user_idx;
    logic [RQE_QUEUE_W-1:0] queue;
    logic [RQE_INFO_W-1:0] ptr;
    logic [RQE_INFO_W-1:0] pkt_ptr;
    logic bad_frames;
    logic dir_up;
    logic [RQE_CTR_W-1:0] ctr_map;
  } rqe_req_t;

  // One word handed to the receive queue.
  typedef struct packed {
    logic [RQE_QUEUE_W-1:0] queue;
    logic [RQE_WORD_W-1:0] word;
  } rqe_evt_t;

endpackage : rqe_pkg

// [bench/rqe_queue_model.sv]
// Receive queue model: takes event words the way a host dequeue loop would.
`timescale 1ns/100ps
module rqe_queue_model
  import rqe_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Pacing chosen by the bench.
  input wire logic i_slow,
  // Event word from the encoder.
  input wire logic i_evt_valid,
  input wire rqe_evt_t i_evt,
  output logic o_evt_ready
);
  rqe_evt_t got[$];
  logic [1:0] pace_r;

  // Slow mode opens the queue one cycle in three, so words must stand while it waits.
  always @(negedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pace_r <= 2'h0;
      o_evt_ready <= 1'b0;
    end else begin
      pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
      o_evt_ready <= !i_slow || (pace_r == 2'h1);
    end
  end

  // Each entry taken is one whole word; the host splits type from info by the low six bits.
  always @(posedge i_clk_sys) begin
    if (i_arst_n && i_evt_valid && o_evt_ready) begin
      got.push_back(i_evt);
    end
  end
endmodule : rqe_queue_model

// [bench/tb.sv]
// Self-checking bench for the receive event word encoder.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb
  import rqe_pkg::*;
;
  localparam logic [5:0] EXP_T [36] = '{6'h0C, 6'h0D, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
    6'h15, 6'h16, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1E, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23,
    6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h29, 6'h2C, 6'h2D, 6'h2E, 6'h2F, 6'h38, 6'h39,
    6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h3E};
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_req_valid = 1'b0;
  rqe_req_t i_req = '0;
  logic [RQE_QUEUE_W-1:0] i_abr_queue = 4'hA;
  logic i_ts_enable = 1'b0;
  logic [RQE_INFO_W-1:0] i_timestamp = 26'h0;
  logic slow = 1'b0;
  logic o_req_ready;
  logic o_evt_valid;
  logic i_evt_ready;
  logic o_tx_cancel;
  logic o_desc_abandon;
  rqe_evt_t o_evt;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  rqe_encoder dut_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .i_abr_queue(i_abr_queue),
    .i_ts_enable(i_ts_enable), .i_timestamp(i_timestamp), .o_evt_valid(o_evt_valid),
    .o_evt(o_evt), .i_evt_ready(i_evt_ready), .o_tx_cancel(o_tx_cancel),
    .o_desc_abandon(o_desc_abandon));
  rqe_queue_model q_u (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_slow(slow),
    .i_evt_valid(o_evt_valid), .i_evt(o_evt), .o_evt_ready(i_evt_ready));

  // Clock of 4 ns.
  always #2 i_clk_sys = ~i_clk_sys;

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // Expected word, worked out independently of the design.
  function automatic logic [31:0] exp_word(input rqe_req_t r);
    logic [25:0] info;
    info = r.ptr;
    if (r.cause inside {RQE_C_VMEM, RQE_C_BUF_OVF, RQE_C_CT_NO_DESC} && r.bad_frames) begin
      info = r.pkt_ptr;
    end
    if (r.cause inside {RQE_C_THRESH1, RQE_C_THRESH2}) begin
      info[0] = r.dir_up;
    end
    if (r.cause == RQE_C_CTR_OVF) begin
      info = {r.ctr_map, 17'h0};
    end
    if (r.cause == RQE_C_USER) begin
      return {info, 3'h6, r.user_idx};
    end
    return {info, EXP_T[r.cause]};
  endfunction : exp_word

  function automatic logic [3:0] exp_queue(input rqe_req_t r);
    if (r.cause inside {RQE_C_ABR_ADT, RQE_C_ABR_NO_BRM, RQE_C_ABR_CCR0, RQE_C_ABR_RM_RX}) begin
      return i_abr_queue;
    end
    return r.queue;
  endfunction : exp_queue

  task automatic wait_ready();
    int w;
    w = 0;
    while (o_req_ready !== 1'b1 && w < 50) begin
      @(negedge i_clk_sys);
      w++;
    end
    `CHK(o_req_ready, 1'b1)
  endtask : wait_ready

  // One request through to the queue, with pulses and words judged.
  task automatic post(input rqe_req_t r, input logic ts);
    int n;
    n = ts ? 2 : 1;
    q_u.got.delete();
    @(negedge i_clk_sys);
    i_req = r;
    i_ts_enable = ts;
    i_req_valid = 1'b1;
    wait_ready();
    @(negedge i_clk_sys);
    i_req_valid = 1'b0;
    `CHK(o_tx_cancel, r.cause == RQE_C_TX_BAD)
    `CHK(o_desc_abandon, r.cause inside {RQE_C_DMA_VIRT, RQE_C_DMA_ZERO})
    `CHK(o_req_ready, 1'b0)
    @(negedge i_clk_sys);
    `CHK(o_tx_cancel | o_desc_abandon, 1'b0)
    wait_ready();
    `CHK(q_u.got.size(), n)
    if (q_u.got.size() == n) begin
      if (ts) begin
        `CHK(q_u.got[0].word, {i_timestamp, 6'h3F})
        `CHK(q_u.got[0].queue, exp_queue(r))
      end
      `CHK(q_u.got[n-1].word, exp_word(r))
      `CHK(q_u.got[n-1].queue, exp_queue(r))
      `CHK(q_u.got[n-1].word[5:0] != 6'h17, 1'b1)
    end
  endtask : post

  task automatic t_reset_values();
    `CHK(o_req_ready, 1'b1)
    `CHK(o_evt_valid, 1'b0)
    `CHK(o_evt, 36'h0)
  endtask : t_reset_values

  // Every producer cause, twice, flipping direction, bad-frame mode and pacing.
  task automatic t_all_causes();
    rqe_req_t r;
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      for (int c = 0; c < 37; c++) begin
        r = '0;
        r.cause = rqe_cause_t'(c[5:0]);
        r.user_idx = 3'h5;
        r.queue = k[0] ? 4'h3 : 4'hC;
        r.ptr = k[0] ? 26'h2AA_AAAA : 26'h155_5555;
        r.pkt_ptr = 26'h0F0_F0F0;
        r.bad_frames = k[0];
        r.dir_up = !k[0];
        r.ctr_map = k[0] ? 9'h1A5 : 9'h05A;
        post(r, 1'b0);
      end
    end
    slow = 1'b0;
  endtask : t_all_causes

  // All eight user codes, only when software asks for them.
  task automatic t_user_codes();
    rqe_req_t r;
    r = '0;
    r.cause = RQE_C_USER;
    r.ptr = 26'h3FF_FFFF;
    for (int u = 0; u < 8; u++) begin
      r.user_idx = u[2:0];
      post(r, 1'b0);
    end
  endtask : t_user_codes

  // Stamp word ahead of its event, with a slow host and ABR routing.
  task automatic t_stamp();
    rqe_req_t r;
    slow = 1'b1;
    r = '0;
    r.queue = 4'h6;
    r.ptr = 26'h123_4567;
    i_timestamp = 26'h3C3_C3C3;
    i_abr_queue = 4'h5;
    r.cause = RQE_C_ABR_CCR0;
    post(r, 1'b1);
    i_timestamp = 26'h000_0001;
    r.cause = RQE_C_SCATTER;
    post(r, 1'b1);
    slow = 1'b0;
    i_ts_enable = 1'b0;
  endtask : t_stamp

  // Reset arriving while a word waits on a stalled host clears the output.
  task automatic t_reset_mid();
    rqe_req_t r;
    slow = 1'b1;
    r = '0;
    r.cause = RQE_C_POOL;
    r.ptr = 26'h0AB_CDEF;
    @(negedge i_clk_sys);
    i_req = r;
    i_req_valid = 1'b1;
    wait_ready();
    @(negedge i_clk_sys);
    i_req_valid = 1'b0;
    i_arst_n = 1'b0;
    @(negedge i_clk_sys);
    t_reset_values();
    i_arst_n = 1'b1;
    slow = 1'b0;
    post(r, 1'b0);
  endtask : t_reset_mid

  // Main sequence.
  initial begin
    repeat (10) @(negedge i_clk_sys);
    t_reset_values();
    i_arst_n = 1'b1;
    t_all_causes();
    t_user_codes();
    t_stamp();
    t_reset_mid();
    end_of_test();
  end
endmodule : tb
